// [sram_ctl_pkg.sv]
// Constants for the asynchronous static memory host controller
package sram_ctl_pkg;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 25;
  // Timing figures in ns
  localparam int T_RC_NS = 70;
  localparam int T_WC_NS = 70;
  localparam int T_PWE_NS = 50;
  localparam int T_HZWE_NS = 25;
  localparam int T_HZOE_NS = 25;
  localparam int T_SD_NS = 30;
  localparam int T_HD_NS = 0;
  // Minimum times round up to whole cycles, never below one
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_min
  localparam int RD_CYC = cyc_min(T_RC_NS);
  localparam int WR_CYC = cyc_min(T_PWE_NS);
  localparam int WR_OE_CYC = cyc_min(T_HZWE_NS + T_SD_NS);
  localparam int TURN_CYC = cyc_min(T_HZOE_NS);
  localparam int CNT_W = 4;
endpackage : sram_ctl_pkg

// [sram_cycle_timer.sv]
// Down counter that times each phase of a memory cycle
`timescale 1ns/10ps
module sram_cycle_timer
  import sram_ctl_pkg::*;
#(
  parameter int W = CNT_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic done
);
  logic [W-1:0] cnt_r;
  // Load with phase length, count down to zero
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= value;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end
  // Done looks only at the count, so loads that depend on it form no loop
  assign done = (cnt_r == '0);
endmodule : sram_cycle_timer

// [sram_host_ctl.sv]
// Host controller driving a 512K x 8 asynchronous static memory
`timescale 1ns/10ps
module sram_host_ctl
  import sram_ctl_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [AW-1:0] REQ_ADDR,
  input wire logic [DW-1:0] REQ_WDATA,
  output logic REQ_READY,
  output logic RSP_VALID,
  output logic [DW-1:0] RSP_RDATA,
  output logic [AW-1:0] MEM_ADDR,
  output logic MEM_SEL_N,
  output logic MEM_WR_N,
  output logic MEM_GATE_N,
  input wire logic [DW-1:0] MEM_DQ_I,
  output logic [DW-1:0] MEM_DQ_O,
  output logic MEM_DQ_OE
);
  // Phases of one memory cycle; setup lets the address settle first
  typedef enum logic [2:0] {
    S_IDLE, S_RSETUP, S_READ, S_WSETUP, S_WRITE, S_WHOLD, S_TURN
  } state_t;

  state_t state_r, state_nxt;
  logic [AW-1:0] addr_r;
  logic [DW-1:0] wdata_r, rdata_r;
  logic rsp_r, sel_n_r, wr_n_r, gate_n_r, oe_r;
  logic [DW-1:0] dq_s1_r, dq_s2_r;
  logic load;
  logic [CNT_W-1:0] load_val;
  logic done;

  // Larger of two cycle counts
  function automatic int max_cyc(input int x, input int y);
    return (x > y) ? x : y;
  endfunction : max_cyc

  // Timer loads per phase; a loaded value n holds the phase n+1 cycles
  // Read window keeps two extra cycles for the data synchroniser
  localparam logic [CNT_W-1:0] SETUP_LEN = CNT_W'(1);
  localparam logic [CNT_W-1:0] READ_LEN = CNT_W'(RD_CYC + 2);
  localparam logic [CNT_W-1:0] WRITE_LEN =
    CNT_W'(max_cyc(WR_CYC, WR_OE_CYC));
  localparam logic [CNT_W-1:0] HOLD_LEN = CNT_W'(1);
  localparam logic [CNT_W-1:0] TURN_LEN = CNT_W'(TURN_CYC);

  // Phase timer
  sram_cycle_timer #(.W(CNT_W)) u_timer (
    .clk(MCLK),
    .rst(RST),
    .load(load),
    .value(load_val),
    .done(done)
  );

  // Read data pins come from outside the clock domain
  // The captured byte lags the pins by two cycles; the read window covers it
  always_ff @(posedge MCLK) begin
    dq_s1_r <= MEM_DQ_I;
    dq_s2_r <= dq_s1_r;
  end

  // Next state and phase loads
  always_comb begin
    state_nxt = state_r;
    load = 1'b0;
    load_val = '0;
    case (state_r)
      // Take one request, then let the address settle for two cycles
      S_IDLE: begin
        if (REQ_VALID) begin
          load = 1'b1;
          load_val = SETUP_LEN;
          state_nxt = REQ_WRITE ? S_WSETUP : S_RSETUP;
        end
      end
      // Address stands before select falls
      S_RSETUP: begin
        if (done) begin
          load = 1'b1;
          load_val = READ_LEN;
          state_nxt = S_READ;
        end
      end
      // Select and gate low for the access plus the synchroniser
      S_READ: begin
        if (done) begin
          load = 1'b1;
          load_val = TURN_LEN;
          state_nxt = S_TURN;
        end
      end
      // Write data driven two cycles before the strobe overlap
      S_WSETUP: begin
        if (done) begin
          load = 1'b1;
          load_val = WRITE_LEN;
          state_nxt = S_WRITE;
        end
      end
      // Overlap long enough for strobe width and turnoff plus setup
      S_WRITE: begin
        if (done) begin
          load = 1'b1;
          load_val = HOLD_LEN;
          state_nxt = S_WHOLD;
        end
      end
      // Data still driven after select and strobe rise together
      S_WHOLD: begin
        if (done) begin
          state_nxt = S_IDLE;
        end
      end
      // Device releases the data pins before the next cycle
      S_TURN: begin
        if (done) begin
          state_nxt = S_IDLE;
        end
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  // Pin levels for each phase
  // Select is low only in the read and write windows; setup, hold and
  // turnaround phases leave the device deselected
  wire req_take = (state_r == S_IDLE) && REQ_VALID;
  wire sel_nxt = (state_nxt == S_READ) || (state_nxt == S_WRITE);
  wire wr_nxt = (state_nxt == S_WRITE);
  wire gate_nxt = (state_nxt == S_READ);
  wire oe_nxt = (state_nxt == S_WSETUP) || (state_nxt == S_WRITE) ||
                (state_nxt == S_WHOLD);
  wire rd_end = (state_r == S_READ) && done;

  // State register
  always_ff @(posedge MCLK) begin
    if (RST) begin
      state_r <= S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Controls: select and strobe rise together at write end, data held
  always_ff @(posedge MCLK) begin
    if (RST) begin
      sel_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      gate_n_r <= 1'b1;
      oe_r <= 1'b0;
    end else begin
      sel_n_r <= !sel_nxt;
      wr_n_r <= !wr_nxt;
      gate_n_r <= !gate_nxt;
      oe_r <= oe_nxt;
    end
  end

  // Read response pulse, one cycle, as select and gate rise
  always_ff @(posedge MCLK) begin
    if (RST) begin
      rsp_r <= 1'b0;
    end else begin
      rsp_r <= rd_end;
    end
  end

  // Address and data latched at request; address set before select
  always_ff @(posedge MCLK) begin
    if (RST) begin
      addr_r <= '0;
      wdata_r <= '0;
    end else if (req_take) begin
      addr_r <= REQ_ADDR;
      wdata_r <= REQ_WDATA;
    end
  end

  // Read byte taken from the synchronised pins as the window closes;
  // it stands until the next read ends
  always_ff @(posedge MCLK) begin
    if (RST) begin
      rdata_r <= '0;
    end else if (rd_end) begin
      rdata_r <= dq_s2_r;
    end
  end

  // Host side handshake and read response
  assign REQ_READY = (state_r == S_IDLE);
  assign RSP_VALID = rsp_r;
  assign RSP_RDATA = rdata_r;

  // Memory pins, all straight from flip-flops
  assign MEM_ADDR = addr_r;
  assign MEM_SEL_N = sel_n_r;
  assign MEM_WR_N = wr_n_r;
  assign MEM_GATE_N = gate_n_r;
  assign MEM_DQ_O = wdata_r;
  assign MEM_DQ_OE = oe_r;
endmodule : sram_host_ctl

// [sram_host_ctl_checker.sv]
// Checker for the memory pin sequencing of the host controller
`timescale 1ns/10ps
module sram_host_ctl_checker
  import sram_ctl_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic RSP_VALID,
  input wire logic [ADDR_W-1:0] MEM_ADDR,
  input wire logic MEM_SEL_N,
  input wire logic MEM_WR_N,
  input wire logic MEM_GATE_N,
  input wire logic [DATA_W-1:0] MEM_DQ_O,
  input wire logic MEM_DQ_OE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  // Pin relations over each memory cycle
  a_write_drive: assert property (!MEM_SEL_N && !MEM_WR_N |-> MEM_DQ_OE)
    else $error("write without data drive");
  a_read_span: assert property ($fell(MEM_GATE_N) |->
    (!MEM_SEL_N && !MEM_GATE_N)[*6] ##1 (MEM_SEL_N && MEM_GATE_N && RSP_VALID))
    else $error("read window wrong");
  a_write_span: assert property ($fell(MEM_WR_N) |->
    (!MEM_SEL_N && !MEM_WR_N)[*4] ##1 (MEM_SEL_N && MEM_WR_N))
    else $error("write window wrong");
  a_data_hold: assert property ($rose(MEM_WR_N) |->
    MEM_DQ_OE && $stable(MEM_DQ_O)) else $error("write data not held");
  a_gate_off_wr: assert property ($fell(MEM_WR_N) |-> MEM_GATE_N[*4])
    else $error("gate low in write");
  a_no_contend: assert property (MEM_DQ_OE |-> MEM_GATE_N)
    else $error("bus contention");
  a_addr_stable: assert property (!MEM_SEL_N |-> $stable(MEM_ADDR))
    else $error("address moved while selected");
  // Main scenarios reached
  c_read: cover property (RSP_VALID);
  c_write: cover property ($rose(MEM_WR_N));
  c_back: cover property ($rose(MEM_WR_N) ##[1:8] $fell(MEM_SEL_N));
endmodule : sram_host_ctl_checker

// [sram_mem.sv]
// Behavioural model of the 512K x 8 asynchronous static memory
`timescale 1ns/10ps
module sram_mem (
  input wire logic sel_n,
  input wire logic wr_n,
  input wire logic gate_n,
  input wire logic [18:0] a,
  input wire logic [7:0] d,
  output logic [7:0] q = 8'h00
);
  logic [7:0] m [int];
  // Store through the overlap; value at its end wins
  always @(sel_n, wr_n, a, d) begin
    if (!sel_n && !wr_n) begin
      m[a] = d;
    end
  end
  // Drive in read mode only; a released bus shows the inverse
  always @(sel_n, wr_n, gate_n, a) begin
    if (!sel_n && wr_n && !gate_n) begin
      q = m.exists(a) ? m[a] : 8'h5a;
    end else begin
      q = ~q;
    end
  end
endmodule : sram_mem

// [sram_host_ctl_bench.sv]
// Self-checking bench for the static memory host controller
`timescale 1ns/10ps
module sram_host_ctl_bench;
  import sram_ctl_pkg::*;
  logic clk = 0, rst = 1, v = 0, w = 0, rdy, rsv, sel_n, wr_n, gate_n, oe;
  logic [ADDR_W-1:0] a = 0, ma, ad;
  logic [DATA_W-1:0] d = 0, rd, dqo, q;
  logic [7:0] ref_m [int];
  int failures = 0, n_compared = 0;
  wire [7:0] dq = oe ? dqo : q;
  always #12.5 clk = ~clk;
  sram_host_ctl dut (.MCLK(clk), .RST(rst), .REQ_VALID(v), .REQ_WRITE(w),
    .REQ_ADDR(a), .REQ_WDATA(d), .REQ_READY(rdy), .RSP_VALID(rsv),
    .RSP_RDATA(rd), .MEM_ADDR(ma), .MEM_SEL_N(sel_n), .MEM_WR_N(wr_n),
    .MEM_GATE_N(gate_n), .MEM_DQ_I(dq), .MEM_DQ_O(dqo), .MEM_DQ_OE(oe));
  sram_mem mem (.sel_n(sel_n), .wr_n(wr_n), .gate_n(gate_n), .a(ma),
    .d(dq), .q(q));
  task chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %0t saw %h want %h", $time, s, e);
    end
  endtask : chk
  task test_done;
    $display("compared %0d failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // One request held until taken; reads compared with the reference copy ref_m
  task op(input logic wr, input logic [18:0] ad, input logic [7:0] dt);
    int i;
    @(posedge clk);
    v <= 1;
    w <= wr;
    a <= ad;
    d <= dt;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (rdy === 1'b1) break;
    end
    v <= 0;
    if (wr) ref_m[ad] = dt;
    else for (i = 0; i < 20; i++) begin
      @(posedge clk);
      #1;
      if (rsv === 1'b1) break;
    end
    if (i == 20) begin
      failures++;
      test_done;
    end
    if (!wr) chk(rd, ref_m[ad]);
  endtask : op
  // Reset, boundary addresses, then a random mix
  initial begin
    void'($urandom(32'h35e9fd69));
    repeat (12) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    #1;
    chk({3'h0, sel_n, wr_n, gate_n, oe, rdy}, 8'h1d);
    op(1, 0, 8'ha5);
    op(1, 19'h7ffff, 8'h3c);
    op(1, 0, 8'h5a);
    op(0, 0, 0);
    op(0, 19'h7ffff, 0);
    $display("edge test done");
    repeat (40) begin
      ad = 19'($urandom_range(31)) * 19'h3ffc;
      if ($urandom_range(1) || !ref_m.exists(ad)) op(1, ad, 8'($urandom));
      else op(0, ad, 0);
    end
    $display("random test done");
    test_done;
  end
endmodule : sram_host_ctl_bench
bind sram_host_ctl sram_host_ctl_checker chk_i (.MCLK(MCLK), .RST(RST),
  .RSP_VALID(RSP_VALID), .MEM_ADDR(MEM_ADDR), .MEM_SEL_N(MEM_SEL_N),
  .MEM_WR_N(MEM_WR_N), .MEM_GATE_N(MEM_GATE_N), .MEM_DQ_O(MEM_DQ_O),
  .MEM_DQ_OE(MEM_DQ_OE));
